// >>> hw/dso_pkg.sv
package dso_pkg;
	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_MODE      = 8'h10;
	localparam logic [7:0] ADDR_SWITCH    = 8'h14;
	localparam logic [7:0] ADDR_A_DELAY   = 8'h30;
	localparam logic [7:0] ADDR_A_SPACING = 8'h31;
	localparam logic [7:0] ADDR_B_DELAY   = 8'h35;
	localparam logic [7:0] ADDR_B_SPACING = 8'h36;
	localparam logic [7:0] ADDR_A_RESULT  = 8'h60;
	localparam logic [7:0] ADDR_B_RESULT  = 8'h61;
	localparam logic [7:0] ADDR_STATUS    = 8'h62;
	localparam logic [7:0] ADDR_SLOT_EN   = 8'h63;
	// ------------------------------------------------------------
	// fields and values
	// ------------------------------------------------------------
	localparam logic [1:0] MODE_STANDBY = 2'h0;
	localparam logic [1:0] MODE_NORMAL  = 2'h2;
	localparam logic [3:0] SW_FLOAT     = 4'h0;
	localparam logic [3:0] SW_ALL       = 4'h1;
	localparam logic [3:0] SW_UPPER     = 4'h4;
	localparam logic [3:0] SW_LOWER     = 4'h5;
	localparam int         SW_A_LSB     = 4;
	localparam int         SW_B_LSB     = 8;
	localparam int         CNT_LSB      = 8;
	localparam logic [15:0] RST_DELAY   = 16'h0017;
	localparam logic [15:0] RST_SPACING = 16'h0113;
	localparam logic [15:0] RST_ZERO    = 16'h0000;
	localparam logic [1:0]  RST_SLOT_EN = 2'h3;
	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_MHZ        = 100;
	localparam int US_CYCLES      = CLK_MHZ;
	localparam int COMPUTE_A_US   = 68;
	localparam int COMPUTE_B_US   = 20;
	localparam int SLEEP_MIN_US   = 222;
	localparam int SAMPLE_KHZ     = 32;
	localparam int SAMPLE_DIV     = (CLK_MHZ * 1000) / SAMPLE_KHZ;
	localparam int SAMPLE_PERIODS = 32;
	localparam int EMIT_US        = 3;
	// ------------------------------------------------------------
	// sequencer states
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE, ST_WAIT, ST_A_RUN, ST_A_CALC, ST_B_RUN, ST_B_CALC, ST_SLEEP
	} dso_state_t;
endpackage

// >>> hw/dso_tick.sv
`timescale 1ns/1ns
`default_nettype none
// restartable divider giving a one-cycle strobe every DIV cycles
module dso_tick
	import dso_pkg::*;
#(
	parameter int DIV = US_CYCLES
) (
	// clock and reset
	input  wire logic clk_sys,
	input  wire logic rst_b,
	input  wire logic ce,
	// control
	input  wire logic restart,
	output logic      tick
);
	typedef struct packed {
		logic [15:0] cnt;  // cycles since last strobe
		logic        tick; // strobe
	} dso_tick_st_t;
	dso_tick_st_t s_reg, s_next;

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		s_next      = s_reg;
		s_next.tick = 1'b0;
		if (restart) begin
			s_next.cnt = 16'h0000;
		end else if (s_reg.cnt == 16'(DIV - 1)) begin
			s_next.cnt  = 16'h0000;
			s_next.tick = 1'b1;
		end else begin
			s_next.cnt = s_reg.cnt + 16'h0001;
		end
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			s_reg <= '0;
		end else if (ce) begin
			s_reg <= s_next;
		end
	end

	assign tick = s_reg.tick;
endmodule
`default_nettype wire

// >>> hw/dso_switch.sv
`timescale 1ns/1ns
`default_nettype none
// photodiode input switch: maps a 4-bit selection to connect enables
module dso_switch
	import dso_pkg::*;
(
	// selection
	input  wire logic [3:0] sel,
	input  wire logic       active,
	// eight-input connect enables and four channel enables
	output logic      [7:0] pd_connect,
	output logic      [3:0] chan_route
);
	// ------------------------------------------------------------
	// decode; reserved codes float the inputs for safety
	// ------------------------------------------------------------
	always_comb begin
		pd_connect = 8'h00;
		chan_route = 4'h0;
		if (active) begin
			case (sel)
				SW_ALL: begin
					pd_connect = 8'hFF;
					chan_route = 4'h3; // combined inputs to channels 1 and 2
				end
				SW_UPPER: begin
					pd_connect = 8'hF0;
					chan_route = 4'h0;
				end
				SW_LOWER: begin
					pd_connect = 8'h0F;
					chan_route = 4'hF; // each input on two channels
				end
				default: begin
					pd_connect = 8'h00;
					chan_route = 4'h0;
				end
			endcase
		end
	end
endmodule
`default_nettype wire

// >>> hw/dso_seq.sv
// The strobed register port was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
// dual slot optical sequencer
module dso_seq
	import dso_pkg::*;
#(
	parameter int SAMPLE_TICKS = SAMPLE_PERIODS // sample clock ticks per period
) (
	// clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst_b,
	input  wire logic        ce,
	// register port
	input  wire logic [7:0]  reg_addr,
	input  wire logic [15:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [15:0] reg_rdata,
	// front end result inputs
	input  wire logic [15:0] adc_result,
	// emitters and photodiode switch
	output logic             first_slot_emitter,
	output logic             second_slot_emitter,
	output logic      [7:0]  pd_connect,
	output logic      [3:0]  chan_route
);
	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		dso_state_t  st;          // sequencer state
		logic [1:0]  mode;        // operating mode
		logic [15:0] sw;          // input switch register
		logic [15:0] a_delay;     // slot A delay register
		logic [15:0] a_spacing;   // slot A count and spacing
		logic [15:0] b_delay;     // slot B delay register
		logic [15:0] b_spacing;   // slot B count and spacing
		logic [1:0]  slot_en;     // slot enables, bit0 A
		logic [15:0] a_result;    // slot A result store
		logic [15:0] b_result;    // slot B result store
		logic [15:0] us_cnt;      // microseconds in phase
		logic [7:0]  pulses;      // unused; held at zero
		logic [15:0] samp_cnt;    // sample ticks in period
		logic        period_due;  // period boundary seen
		logic        emit_a;      // emitter outputs
		logic        emit_b;
		logic [7:0]  pd;          // registered switch outputs
		logic [3:0]  ch;
		logic [15:0] rdata;       // read data
		logic [1:0]  done;        // sticky slot complete flags
	} dso_st_t;
	dso_st_t s_reg, s_next;
	// one struct holds every flop; the next state
	// logic fills a copy and one process registers it
	// limitation: only the latest result word per slot
	// is kept, there is no history buffer here
	// trade-off: results are taken at slot end, so a
	// host read during a slot sees the previous period

	logic       us_tick;   // one-microsecond strobe
	logic       samp_tick; // 32 kHz sample strobe
	logic       us_restart;
	logic [7:0] sw_pd;
	logic [3:0] sw_ch;
	logic [3:0] sw_sel;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	// both slots share these helpers; each call only
	// gets the settings of its own slot
	// count sits in bits 15:8, spacing in bits 7:0
	// the product stays in 16 bits: 255 x 255 plus a
	// delay of 255 is 65280, so it never overflows
	// time into slot at which its last pulse period ends
	function automatic logic [15:0] slot_len(input logic [15:0] dly, input logic [15:0] sp);
		slot_len = dly[7:0] + 16'(sp[15:CNT_LSB]) * sp[7:0];
	endfunction

	// emitter on during the first microseconds of each pulse period
	function automatic logic emit_on(input logic [15:0] t, input logic [15:0] dly,
	                                 input logic [15:0] sp);
		logic [15:0] rel;
		rel     = 16'h0000;
		emit_on = 1'b0;
		if (t >= 16'(dly[7:0]) && t < slot_len(dly, sp) && sp[7:0] != 8'h00) begin
			rel     = t - 16'(dly[7:0]);
			emit_on = (rel % 16'(sp[7:0])) < 16'(EMIT_US);
		end
	endfunction

	// ------------------------------------------------------------
	// time bases
	// ------------------------------------------------------------
	// microsecond strobe; restarted at each phase
	// change so every phase counts from a clean edge
	// the 32 kHz strobe below runs free
	dso_tick #(
		.DIV (US_CYCLES)
	) u_us (
		.clk_sys (clk_sys),
		.rst_b   (rst_b),
		.ce      (ce),
		.restart (us_restart),
		.tick    (us_tick)
	);

	dso_tick #(
		.DIV (SAMPLE_DIV)
	) u_samp (
		.clk_sys (clk_sys),
		.rst_b   (rst_b),
		.ce      (ce),
		.restart (1'b0),
		.tick    (samp_tick)
	);

	// the switch follows whichever slot is running
	assign sw_sel = (s_reg.st == ST_B_RUN) ? s_reg.sw[SW_B_LSB +: 4]
	                                       : s_reg.sw[SW_A_LSB +: 4];

	dso_switch u_sw (
		.sel        (sw_sel),
		.active     (s_reg.st == ST_A_RUN || s_reg.st == ST_B_RUN),
		.pd_connect (sw_pd),
		.chan_route (sw_ch)
	);

	// microsecond counter restarts at every phase change
	assign us_restart = (s_next.st != s_reg.st);

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		s_next = s_reg;
		// sample clock paces periods; a boundary is held until wait uses it, or sleep or leaving idle drops it
		if (samp_tick) begin
			if (s_reg.samp_cnt >= 16'(SAMPLE_TICKS - 1)) begin
				s_next.samp_cnt   = 16'h0000;
				s_next.period_due = 1'b1;
			end else begin
				s_next.samp_cnt = s_reg.samp_cnt + 16'h0001;
			end
		end
		if (us_tick) begin
			s_next.us_cnt = s_reg.us_cnt + 16'h0001;
		end
		// ------------------------------------------------------------
		// sequencer
		// ------------------------------------------------------------
		case (s_reg.st)
			ST_IDLE: begin
				// parked until the host selects normal mode
				if (s_reg.mode == MODE_NORMAL) begin
					s_next.st         = ST_WAIT;
					s_next.period_due = 1'b0;
				end
			end
			ST_WAIT: begin
				// wait for the next period boundary
				if (s_reg.period_due) begin
					s_next.period_due = 1'b0;
					// an unused slot adds no time at all
					if (s_reg.slot_en[0]) begin
						s_next.st = ST_A_RUN;
					end else if (s_reg.slot_en[1]) begin
						s_next.st = ST_B_RUN;
					end else begin
						s_next.st = ST_SLEEP;
					end
				end
			end
			ST_A_RUN: begin
				// slot a pulsing; result taken as it ends
				if (s_reg.us_cnt >= slot_len(s_reg.a_delay, s_reg.a_spacing)) begin
					s_next.st       = ST_A_CALC;
					s_next.a_result = adc_result;
				end
			end
			ST_A_CALC: begin
				// fixed slot a compute interval
				if (s_reg.us_cnt >= 16'(COMPUTE_A_US)) begin
					s_next.done[0] = 1'b1;
					s_next.st      = s_reg.slot_en[1] ? ST_B_RUN : ST_SLEEP;
				end
			end
			ST_B_RUN: begin
				// slot b pulsing; result taken as it ends
				if (s_reg.us_cnt >= slot_len(s_reg.b_delay, s_reg.b_spacing)) begin
					s_next.st       = ST_B_CALC;
					s_next.b_result = adc_result;
				end
			end
			ST_B_CALC: begin
				// fixed slot b compute interval
				if (s_reg.us_cnt >= 16'(COMPUTE_B_US)) begin
					s_next.done[1] = 1'b1;
					s_next.st      = ST_SLEEP;
				end
			end
			ST_SLEEP: begin
				// minimum sleep; counted from its own start
				// boundaries during sleep are dropped so sleep is never cut short
				s_next.period_due = 1'b0;
				if (s_reg.us_cnt >= 16'(SLEEP_MIN_US)) begin
					s_next.st = ST_WAIT;
				end
			end
			default: begin
				// unused codes recover to idle
				s_next.st = ST_IDLE;
			end
		endcase
		// leaving normal mode stops at once
		if (s_reg.mode != MODE_NORMAL) begin
			// standby or any other mode parks in idle
			s_next.st = ST_IDLE;
		end
		// judged on the final next state, so a forced
		// idle restarts the count as well
		if (s_next.st != s_reg.st) begin
			s_next.us_cnt = 16'h0000;
		end
		// ------------------------------------------------------------
		// emitters and switch
		// ------------------------------------------------------------
		// emitters, each only in its own slot
		s_next.emit_a = (s_reg.st == ST_A_RUN)
		              && emit_on(s_reg.us_cnt, s_reg.a_delay, s_reg.a_spacing);
		s_next.emit_b = (s_reg.st == ST_B_RUN)
		              && emit_on(s_reg.us_cnt, s_reg.b_delay, s_reg.b_spacing);
		s_next.pd = sw_pd;
		s_next.ch = sw_ch;
		// ------------------------------------------------------------
		// register writes; unmapped addresses are ignored
		// ------------------------------------------------------------
		if (reg_wr) begin
			if (reg_addr == ADDR_MODE) begin
				// mode takes effect next cycle
				s_next.mode = reg_wdata[1:0];
			end else if (reg_addr == ADDR_SWITCH) begin
				// both slot selections in one word
				s_next.sw = reg_wdata;
			end else if (reg_addr == ADDR_A_DELAY) begin
				// slot a delay
				s_next.a_delay = reg_wdata;
			end else if (reg_addr == ADDR_A_SPACING) begin
				// slot a count and spacing
				s_next.a_spacing = reg_wdata;
			end else if (reg_addr == ADDR_B_DELAY) begin
				// slot b delay
				s_next.b_delay = reg_wdata;
			end else if (reg_addr == ADDR_B_SPACING) begin
				// slot b count and spacing
				s_next.b_spacing = reg_wdata;
			end else if (reg_addr == ADDR_SLOT_EN) begin
				// a change is seen at the next boundary; the slot b bit also at slot a's end
				s_next.slot_en = reg_wdata[1:0];
			end
		end
		// ------------------------------------------------------------
		// register reads; status read clears done flags, new completion wins
		// ------------------------------------------------------------
		s_next.rdata = 16'h0000;
		if (reg_rd) begin
			if (reg_addr == ADDR_MODE) begin
				// mode in the two low bits
				s_next.rdata = {14'h0000, s_reg.mode};
			end else if (reg_addr == ADDR_SWITCH) begin
				// input switch word
				s_next.rdata = s_reg.sw;
			end else if (reg_addr == ADDR_A_DELAY) begin
				// slot a delay
				s_next.rdata = s_reg.a_delay;
			end else if (reg_addr == ADDR_A_SPACING) begin
				// slot a count and spacing
				s_next.rdata = s_reg.a_spacing;
			end else if (reg_addr == ADDR_B_DELAY) begin
				// slot b delay
				s_next.rdata = s_reg.b_delay;
			end else if (reg_addr == ADDR_B_SPACING) begin
				// slot b count and spacing
				s_next.rdata = s_reg.b_spacing;
			end else if (reg_addr == ADDR_A_RESULT) begin
				// slot a store, kept apart from slot b
				s_next.rdata = s_reg.a_result;
			end else if (reg_addr == ADDR_B_RESULT) begin
				// slot b store
				s_next.rdata = s_reg.b_result;
			end else if (reg_addr == ADDR_STATUS) begin
				// state code and sticky done flags
				s_next.rdata = {11'h000, 3'(s_reg.st), s_reg.done};
				s_next.done  = s_next.done & ~s_reg.done;
				if (s_reg.st == ST_A_CALC && s_next.st != ST_A_CALC) begin
					s_next.done[0] = 1'b1;
				end
				if (s_reg.st == ST_B_CALC && s_next.st != ST_B_CALC) begin
					s_next.done[1] = 1'b1;
				end
			end else if (reg_addr == ADDR_SLOT_EN) begin
				// slot enables in the two low bits
				s_next.rdata = {14'h0000, s_reg.slot_en};
			end
		end
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			// clear all, then load the power-up settings
			s_reg           <= '0;
			s_reg.st        <= ST_IDLE;
			s_reg.mode      <= MODE_STANDBY;
			s_reg.a_delay   <= RST_DELAY;
			s_reg.b_delay   <= RST_DELAY;
			s_reg.a_spacing <= RST_SPACING;
			s_reg.b_spacing <= RST_SPACING;
			s_reg.sw        <= RST_ZERO;
			s_reg.slot_en   <= RST_SLOT_EN;
		end else if (ce) begin
			s_reg <= s_next;
		end
	end

	// outputs straight from flip-flops
	// no logic sits between these flops and the pins
	assign reg_rdata           = s_reg.rdata;
	assign first_slot_emitter  = s_reg.emit_a;
	assign second_slot_emitter = s_reg.emit_b;
	assign pd_connect          = s_reg.pd;
	assign chan_route          = s_reg.ch;
endmodule
`default_nettype wire

// >>> verification/dso_seq_properties.sv
`timescale 1ns/1ns
`default_nettype none
// port checker: shadows config writes, times the emitters
module dso_seq_properties
	import dso_pkg::*;
#(
	parameter int SAMPLE_TICKS = SAMPLE_PERIODS
) (
	// clock and reset
	input wire logic        clk_sys,
	input wire logic        rst_b,
	input wire logic        ce,
	// register port
	input wire logic [7:0]  reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [15:0] reg_rdata,
	// front end side
	input wire logic [15:0] adc_result,
	input wire logic        first_slot_emitter,
	input wire logic        second_slot_emitter,
	input wire logic [7:0]  pd_connect,
	input wire logic [3:0]  chan_route
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	// --------------------------------------------------
	// helper state
	// --------------------------------------------------
	logic [15:0] sw_q;    // switch shadow
	logic [15:0] ad_q;    // slot a delay shadow
	logic [15:0] as_q;    // slot a count and spacing shadow
	logic [15:0] bd_q;    // slot b delay shadow
	logic [15:0] bs_q;    // slot b count and spacing shadow
	logic [15:0] cfg_mux; // shadow picked by address
	logic        cfg_hit; // address is a config register
	logic [15:0] hi_a;    // cycles emitter a has been lit
	logic [15:0] hi_b;    // cycles emitter b has been lit
	logic [15:0] gap_a;   // cycles since emitter a rose
	logic [15:0] gap_b;   // cycles since emitter b rose
	logic [15:0] idle;    // cycles with both emitters dark, saturating
	// expected {pd_connect, chan_route} for a selection code
	function automatic logic [11:0] route(input logic [3:0] s);
		case (s)
			SW_ALL:   return 12'hFF3;
			SW_UPPER: return 12'hF00;
			SW_LOWER: return 12'h0FF;
			default:  return 12'h000;
		endcase
	endfunction
	// shadows follow accepted writes, as the design's registers do
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			sw_q <= RST_ZERO;
			ad_q <= RST_DELAY;
			as_q <= RST_SPACING;
			bd_q <= RST_DELAY;
			bs_q <= RST_SPACING;
		end else if (ce && reg_wr) begin
			if (reg_addr == ADDR_SWITCH) sw_q <= reg_wdata;
			if (reg_addr == ADDR_A_DELAY) ad_q <= reg_wdata;
			if (reg_addr == ADDR_A_SPACING) as_q <= reg_wdata;
			if (reg_addr == ADDR_B_DELAY) bd_q <= reg_wdata;
			if (reg_addr == ADDR_B_SPACING) bs_q <= reg_wdata;
		end
	end
	// read mux over the shadows
	always_comb begin
		cfg_hit = 1'b1;
		case (reg_addr)
			ADDR_SWITCH:    cfg_mux = sw_q;
			ADDR_A_DELAY:   cfg_mux = ad_q;
			ADDR_A_SPACING: cfg_mux = as_q;
			ADDR_B_DELAY:   cfg_mux = bd_q;
			ADDR_B_SPACING: cfg_mux = bs_q;
			default: begin
				cfg_hit = 1'b0;
				cfg_mux = RST_ZERO;
			end
		endcase
	end
	// gap and idle counters start saturated so the first pulse is never judged short
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			hi_a <= '0;
			hi_b <= '0;
			gap_a <= '1;
			gap_b <= '1;
			idle <= '1;
		end else begin
			hi_a <= first_slot_emitter ? hi_a + 16'h0001 : 16'h0000;
			hi_b <= second_slot_emitter ? hi_b + 16'h0001 : 16'h0000;
			gap_a <= $rose(first_slot_emitter) ? 16'h0001 : gap_a + {15'h0, gap_a != 16'hFFFF};
			gap_b <= $rose(second_slot_emitter) ? 16'h0001 : gap_b + {15'h0, gap_b != 16'hFFFF};
			if (first_slot_emitter || second_slot_emitter) idle <= 16'h0000;
			else if (idle != 16'hFFFF) idle <= idle + 16'h0001;
		end
	end
	// --------------------------------------------------
	// properties
	// --------------------------------------------------
	a_emit_exclusive: assert property (!(first_slot_emitter && second_slot_emitter))
		else $error("both emitters lit together");
	a_width_a: assert property ($fell(first_slot_emitter) |-> hi_a == EMIT_US * US_CYCLES)
		else $error("emitter a pulse width wrong");
	a_width_b: assert property ($fell(second_slot_emitter) |-> hi_b == EMIT_US * US_CYCLES)
		else $error("emitter b pulse width wrong");
	a_spacing_a: assert property ($rose(first_slot_emitter) && gap_a < 16'd6400 |->
		gap_a inside {[as_q[7:0] * US_CYCLES - 1 : as_q[7:0] * US_CYCLES + 1]})
		else $error("emitter a spacing wrong");
	a_spacing_b: assert property ($rose(second_slot_emitter) && gap_b < 16'd6400 |->
		gap_b inside {[bs_q[7:0] * US_CYCLES - 1 : bs_q[7:0] * US_CYCLES + 1]})
		else $error("emitter b spacing wrong");
	a_route_slot_a: assert property (first_slot_emitter |-> {pd_connect, chan_route} == route(sw_q[7:4]))
		else $error("slot a input switch wrong");
	a_route_slot_b: assert property (second_slot_emitter |-> {pd_connect, chan_route} == route(sw_q[11:8]))
		else $error("slot b input switch wrong");
	a_rdata_quiet: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
		else $error("read data outside read cycle");
	a_cfg_readback: assert property (reg_rd && cfg_hit |=> reg_rdata == $past(cfg_mux))
		else $error("config readback wrong");
	a_sleep_gap: assert property ($rose(first_slot_emitter) || $rose(second_slot_emitter) |->
		idle < 16'd19200 || idle >= 16'd26000)
		else $error("sleep between periods too short");
endmodule
bind dso_seq dso_seq_properties #(.SAMPLE_TICKS(SAMPLE_TICKS)) u_props (
	.clk_sys(clk_sys), .rst_b(rst_b), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .adc_result(adc_result),
	.first_slot_emitter(first_slot_emitter), .second_slot_emitter(second_slot_emitter),
	.pd_connect(pd_connect), .chan_route(chan_route)
);
`default_nettype wire

// >>> verification/dso_front_model.sv
`timescale 1ns/1ns
`default_nettype none
// front end stand-in: result tells which slot lit and how often
module dso_front_model (
	// clock and reset
	input wire logic         clk_sys,
	input wire logic         rst_b,
	// emitters
	input wire logic         first_slot_emitter,
	input wire logic         second_slot_emitter,
	// conversion result
	output logic      [15:0] adc_result
);
	logic       last_b; // most recent light came from slot b
	logic [7:0] n_a;    // slot a pulses in the current burst
	logic [7:0] n_b;    // slot b pulses in the current burst
	// a burst restarts its count when the other emitter lit last
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			last_b <= 1'b1;
			n_a <= 8'h00;
			n_b <= 8'h00;
		end else if ($rose(first_slot_emitter)) begin
			n_a <= last_b ? 8'h01 : n_a + 8'h01;
			last_b <= 1'b0;
		end else if ($rose(second_slot_emitter)) begin
			n_b <= last_b ? n_b + 8'h01 : 8'h01;
			last_b <= 1'b1;
		end
	end
	assign adc_result = last_b ? {8'hB0, n_b} : {8'hA0, n_a};
endmodule
`default_nettype wire

// >>> verification/test_dual_slot_optical_sequencer.sv
`timescale 1ns/1ns
`default_nettype none
module test_dual_slot_optical_sequencer
	import dso_pkg::*;
;
	// --------------------------------------------------
	// signals
	// --------------------------------------------------
	logic        clk_sys;
	logic        rst_b;
	logic        ce;
	logic [7:0]  reg_addr;
	logic [15:0] reg_wdata;
	logic        reg_wr;
	logic        reg_rd;
	logic [15:0] reg_rdata;
	logic [15:0] adc_result;
	logic        first_slot_emitter;
	logic        second_slot_emitter;
	logic [7:0]  pd_connect;
	logic [3:0]  chan_route;
	int          mismatches = 0;
	int          checks_done = 0;
	int          cyc = 0;     // cycle stamp
	int          a_rises = 0; // slot a pulses seen
	int          tb_last;     // last slot b rise of the first period
	// one tick per period keeps the run short
	dso_seq #(.SAMPLE_TICKS(1)) dut (
		.clk_sys(clk_sys), .rst_b(rst_b), .ce(ce), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.adc_result(adc_result), .first_slot_emitter(first_slot_emitter),
		.second_slot_emitter(second_slot_emitter), .pd_connect(pd_connect),
		.chan_route(chan_route)
	);
	dso_front_model u_front (
		.clk_sys(clk_sys), .rst_b(rst_b), .first_slot_emitter(first_slot_emitter),
		.second_slot_emitter(second_slot_emitter), .adc_result(adc_result)
	);
	initial clk_sys = 1'b0;
	always #5 clk_sys = ~clk_sys;
	always @(posedge clk_sys) cyc <= cyc + 1;
	always @(posedge first_slot_emitter) a_rises++;
	// --------------------------------------------------
	// bus and check tasks
	// --------------------------------------------------
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	// read data stands only in the cycle after the strobe
	task automatic rdr(input logic [7:0] a, output logic [15:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		@(negedge clk_sys);
		d = reg_rdata;
	endtask
	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic span(input string what, input int lo, input int hi, input int v);
		checks_done++;
		if (v < lo || v > hi) begin
			mismatches++;
			$display("MISMATCH %s expected %0d..%0d seen %0d", what, lo, hi, v);
		end
	endtask
	// bounded wait for an emitter level, returns the cycle stamp
	task automatic wait_lvl(input logic b, input logic lvl, input int lim, output int at);
		int i;
		for (i = 0; i < lim; i++) begin
			@(negedge clk_sys);
			if ((b ? second_slot_emitter : first_slot_emitter) === lvl) break;
		end
		at = cyc;
		if (i == lim) begin
			mismatches++;
			$display("MISMATCH emitter wait expected %0d seen timeout", lvl);
		end
	endtask
	// --------------------------------------------------
	// scenarios
	// --------------------------------------------------
	task automatic reset_values();
		logic [15:0] d;
		rdr(ADDR_A_DELAY, d); check("a_delay", RST_DELAY, d);
		rdr(ADDR_B_DELAY, d); check("b_delay", RST_DELAY, d);
		rdr(ADDR_A_SPACING, d); check("a_spacing", RST_SPACING, d);
		rdr(ADDR_B_SPACING, d); check("b_spacing", RST_SPACING, d);
		rdr(ADDR_SWITCH, d); check("switch", RST_ZERO, d);
		rdr(ADDR_SLOT_EN, d); check("slot_en", {14'h0, RST_SLOT_EN}, d);
		wr(8'h7F, 16'hFFFF);
		rdr(8'h7F, d); check("unmapped", RST_ZERO, d);
	endtask
	task automatic run_two_slots();
		logic [15:0] d;
		int t1, t2, tb, t;
		wr(ADDR_A_DELAY, 16'h0017);
		wr(ADDR_A_SPACING, 16'h0213);
		wr(ADDR_B_DELAY, 16'h001E);
		wr(ADDR_B_SPACING, 16'h0219);
		wr(ADDR_SWITCH, 16'h0150);
		wr(ADDR_MODE, {14'h0, MODE_NORMAL});
		wait_lvl(1'b0, 1'b1, 8000, t1);
		check("route_a", 16'h00FF, {4'h0, pd_connect, chan_route});
		wait_lvl(1'b0, 1'b0, 400, t);
		wait_lvl(1'b0, 1'b1, 2500, t2);
		span("a_pulse_gap", 1898, 1902, t2 - t1);
		wait_lvl(1'b1, 1'b1, 20000, tb);
		check("route_b", 16'h0FF3, {4'h0, pd_connect, chan_route});
		span("a_to_b", 13595, 13605, tb - t1);
		wait_lvl(1'b1, 1'b0, 400, t);
		wait_lvl(1'b1, 1'b1, 2600, tb_last);
		span("b_pulse_gap", 2498, 2502, tb_last - tb);
		repeat (5000) @(posedge clk_sys);
		rdr(ADDR_A_RESULT, d); check("a_result", 16'hA002, d);
		rdr(ADDR_B_RESULT, d); check("b_result", 16'hB002, d);
		rdr(ADDR_STATUS, d); check("done_flags", 16'h0003, {14'h0, d[1:0]});
		rdr(ADDR_STATUS, d); check("done_cleared", 16'h0000, {14'h0, d[1:0]});
	endtask
	// slot a switched off during sleep: next period is slot b alone
	task automatic b_only_period();
		int na, t;
		na = a_rises;
		wr(ADDR_SLOT_EN, 16'h0002);
		wr(ADDR_SWITCH, 16'h0450);
		wait_lvl(1'b1, 1'b1, 40000, t);
		span("sleep_gap", 29700, 32930, t - tb_last);
		check("route_b_upper", 16'h0F00, {4'h0, pd_connect, chan_route});
		span("a_skipped", 0, 0, a_rises - na);
		wr(ADDR_MODE, {14'h0, MODE_STANDBY});
	endtask
	// --------------------------------------------------
	// run control
	// --------------------------------------------------
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	initial begin
		rst_b = 1'b0;
		ce = 1'b1;
		reg_addr = 8'h00;
		reg_wdata = 16'h0000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		repeat (2) @(posedge clk_sys);
		rst_b <= 1'b1;
		reset_values();
		run_two_slots();
		b_only_period();
		tally_and_finish();
	end
	// the sequence needs about 55000 cycles
	initial begin
		repeat (90000) @(posedge clk_sys);
		mismatches++;
		tally_and_finish();
	end
endmodule
`default_nettype wire
